// [hdl/lcbt_top.sv]
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module lcbt_top #(
	parameter int ADDR_W = 32
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic req_valid,
	input wire lcbt_pkg::lcbt_op_t req_op,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [3:0] req_size,
	input wire logic [3:0] page_attribute_bits,
	input wire logic req_hit,
	input wire lcbt_pkg::lcbt_cst_t req_state,
	output logic req_ready,
	output logic req_done,
	output lcbt_pkg::lcbt_cst_t req_next_state,
	input wire logic mem_queue_busy,
	input wire logic tlbsync_hold,
	output logic bus_start,
	output logic [4:0] bus_tt,
	output logic [ADDR_W-1:0] bus_addr,
	output logic [3:0] bus_size,
	output logic transfer_burst_flag,
	output logic bus_addr_only,
	output logic beat_valid,
	output logic [ADDR_W-1:0] beat_addr,
	output logic l2_forward,
	input wire logic snp_valid,
	input wire logic [4:0] snp_tt,
	input wire logic snp_burst,
	output logic snp_flush,
	output logic snp_inhibit,
	output logic snp_kill
);
	import lcbt_pkg::*;

	if (ADDR_W < 6 || ADDR_W > 64) begin : g_bad_width
		$error("ADDR_W must lie between 6 and 64");
	end

	logic [CFG_W-1:0] cfg_ff;
	logic [31:0] rdata_ff;
	logic wait_ff;
	lcbt_state_t state_ff, nxt_state;
	logic [1:0] left_ff, nxt_left;
	logic ready_ff, done_ff, start_ff, burst_ff, aonly_ff, beat_ff, l2_ff;
	logic flush_ff, inh_ff, kill_ff;
	lcbt_cst_t nst_ff;
	logic [4:0] tt_ff;
	logic [ADDR_W-1:0] baddr_ff, beat_addr_ff;
	logic [3:0] size_ff;

	// Register slave: one wait cycle, answer on the second
	wire bus_req = avs_read | avs_write;
	wire take = bus_req & wait_ff;
	wire sel_cfg = avs_address == REG_CFG;
	wire sel_stat = avs_address == REG_STAT;
	// Writes land as the answer is sampled, so a request that never sees it changes nothing
	wire ack = bus_req & !wait_ff;
	wire cfg_we = ack & avs_write & sel_cfg & avs_byteenable[0];
	wire [31:0] stat_word = {{(32-STAT_W){1'b0}}, ready_ff, state_ff};
	wire [31:0] rd_mux = sel_cfg ? {{(32-CFG_W){1'b0}}, cfg_ff} : sel_stat ? stat_word : 32'h0000_0000;
	wire dce = cfg_ff[CFG_DCE_BIT];
	wire data_cache_lock_bit = cfg_ff[CFG_LOCK_BIT];
	wire abe = cfg_ff[CFG_ABE_BIT];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfg_ff <= CFG_RESET;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else begin
			wait_ff <= !take;
			if (cfg_we) begin
				cfg_ff <= avs_writedata[CFG_W-1:0];
			end
			if (take & avs_read) begin
				rdata_ff <= rd_mux;
			end
		end
	end

	// Request decode
	wire accept = req_valid & ready_ff;
	wire is_ci = page_attribute_bits[ATTR_I_BIT];
	wire is_wt = page_attribute_bits[ATTR_W_BIT];
	wire st_m = req_state == CS_M;
	wire miss = !req_hit;
	wire op_st = req_op == OP_STORE;
	wire mem_op = (req_op == OP_LOAD) | op_st | (req_op == OP_FETCH);
	wire touch = (req_op == OP_TOUCH) | (req_op == OP_TOUCH_ST);
	wire op_dcbi = req_op == OP_DCBI;
	wire op_dcbf = req_op == OP_DCBF;
	wire op_dcbst = req_op == OP_DCBST;
	wire op_dcbz = req_op == OP_DCBZ;
	wire op_sync = req_op == OP_SYNC;
	wire op_eieio = req_op == OP_EIEIO;
	wire single_mode = is_wt | is_ci | !dce | data_cache_lock_bit;
	wire single = mem_op & (single_mode | (op_st & is_wt));
	wire fill = (mem_op & miss & !single_mode) | (touch & miss);
	wire push = (op_dcbf | op_dcbst) & st_m;
	// Block-zero broadcasts alone; the rest wait for the enable bit
	wire gated = op_dcbi | ((op_dcbf | op_dcbst) & !st_m) | op_sync | op_eieio;
	wire abcast = op_dcbz | (gated & abe);
	wire go_bus = fill | single | push | abcast;
	wire go_xfer = fill | single | push;
	wire burst = fill | push;
	wire [4:0] rd_tt = is_ci ? TT_READ : TT_READ_INTENT_MODIFY;
	wire [4:0] tt_bc = op_dcbf ? TT_FLUSH : op_dcbst ? TT_CLEAN : op_sync ? TT_SYNC
		: op_eieio ? TT_EIEIO : TT_KILL;
	wire [4:0] tt_sel = fill ? TT_READ_INTENT_MODIFY : single ? (op_st ? TT_WRITE : rd_tt) : push ? TT_WWK : tt_bc;
	wire [ADDR_W-1:0] dw_addr = {req_addr[ADDR_W-1:3], 3'h0};
	wire [ADDR_W-1:0] blk_addr = {req_addr[ADDR_W-1:5], 5'h00};
	// Fills start at the missed double word; pushes at the block start
	wire [ADDR_W-1:0] addr_sel = single ? req_addr : fill ? dw_addr : blk_addr;
	wire [1:0] cur_dw = beat_addr_ff[4:3];
	wire [ADDR_W-1:0] beat_inc = {beat_addr_ff[ADDR_W-1:5], dw_next(cur_dw), 3'h0};
	wire cs_inval = (req_op == OP_ICBI) | op_dcbi | op_dcbf;
	wire cs_mod = op_dcbz | (fill & op_st);
	wire cs_excl = (op_dcbst & st_m) | fill;
	wire lcbt_cst_t nst_sel = cs_inval ? CS_I : cs_mod ? CS_M : cs_excl ? CS_E : req_state;
	wire l2_sel = op_dcbi | op_dcbf | op_dcbst | op_dcbz;
	wire snp_read = (snp_tt == TT_READ) | (snp_tt == TT_READ_INTENT_MODIFY);

	always_comb begin
		nxt_state = state_ff;
		nxt_left = left_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_left = burst ? BURST_LAST : 2'h0;
					if (op_sync) begin
						nxt_state = ST_QWAIT;
					end else if (req_op == OP_TLBSYNC) begin
						nxt_state = ST_TWAIT;
					end else if (go_xfer) begin
						nxt_state = ST_XFER;
					end else begin
						nxt_state = ST_DONE;
					end
				end
			end
			ST_XFER: begin
				if (left_ff == 2'h0) begin
					nxt_state = ST_DONE;
				end else begin
					nxt_left = left_ff - 2'h1;
				end
			end
			ST_QWAIT: begin
				if (!mem_queue_busy) begin
					nxt_state = ST_DONE;
				end
			end
			ST_TWAIT: begin
				if (!tlbsync_hold) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
			left_ff <= 2'h0;
			ready_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			left_ff <= nxt_left;
			ready_ff <= nxt_state == ST_IDLE;
			done_ff <= nxt_state == ST_DONE;
		end
	end

	// Bus side; the transfer fields hold until the next accepted request
	always_ff @(posedge clk) begin
		if (!resetn) begin
			start_ff <= 1'b0;
			l2_ff <= 1'b0;
			beat_ff <= 1'b0;
			tt_ff <= TT_CLEAN;
			baddr_ff <= '0;
			beat_addr_ff <= '0;
			size_ff <= 4'h0;
			burst_ff <= 1'b0;
			aonly_ff <= 1'b0;
			nst_ff <= CS_I;
		end else begin
			start_ff <= accept & go_bus;
			l2_ff <= accept & l2_sel;
			beat_ff <= nxt_state == ST_XFER;
			if (accept) begin
				tt_ff <= tt_sel;
				baddr_ff <= addr_sel;
				beat_addr_ff <= addr_sel;
				size_ff <= burst ? MAX_SINGLE : req_size;
				burst_ff <= burst;
				aonly_ff <= !go_xfer;
				nst_ff <= nst_sel;
			end else if (state_ff == ST_XFER && burst_ff) begin
				beat_addr_ff <= beat_inc;
			end
		end
	end

	// Snoop response; only reads and kill block are acted upon
	always_ff @(posedge clk) begin
		if (!resetn) begin
			flush_ff <= 1'b0;
			inh_ff <= 1'b0;
			kill_ff <= 1'b0;
		end else begin
			flush_ff <= snp_valid & snp_read & snp_burst;
			inh_ff <= snp_valid & snp_read & !snp_burst;
			kill_ff <= snp_valid & (snp_tt == TT_KILL);
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign req_ready = ready_ff;
	assign req_done = done_ff;
	assign req_next_state = nst_ff;
	assign bus_start = start_ff;
	assign bus_tt = tt_ff;
	assign bus_addr = baddr_ff;
	assign bus_size = size_ff;
	assign transfer_burst_flag = burst_ff;
	assign bus_addr_only = aonly_ff;
	assign beat_valid = beat_ff;
	assign beat_addr = beat_addr_ff;
	assign l2_forward = l2_ff;
	assign snp_flush = flush_ff;
	assign snp_inhibit = inh_ff;
	assign snp_kill = kill_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_single_size_range: assert property (start_ff && !burst_ff && !aonly_ff |->
		size_ff != 4'h0 && size_ff <= MAX_SINGLE) else $error("single beat size out of range");
	a_single_mode_beat: assert property (accept && mem_op && single_mode |=>
		start_ff && !burst_ff && beat_ff ##1 !beat_ff) else $error("single mode access not single");
	a_burst_four_beats: assert property (start_ff && burst_ff |->
		beat_ff [*4] ##1 !beat_ff) else $error("burst not four beats");
	a_burst_flag_kind: assert property (start_ff && aonly_ff |-> !burst_ff && !beat_ff)
		else $error("address-only op flagged as burst");
	a_critical_first: assert property (accept && fill |=>
		beat_addr_ff[4:3] == $past(req_addr[4:3]) && beat_addr_ff[2:0] == 3'h0) else $error("fill not critical first");
	a_linear_push: assert property (accept && push |=> beat_addr_ff[4:0] == 5'h00 && tt_ff == TT_WWK)
		else $error("push not block aligned");
	a_read_encoding: assert property (accept && mem_op && !op_st && !is_ci && go_xfer |=>
		tt_ff == TT_READ_INTENT_MODIFY) else $error("cacheable read not intent-to-modify");
	a_snoop_flush: assert property (snp_valid && snp_read |=>
		flush_ff == $past(snp_burst) && inh_ff != flush_ff) else $error("snooped read mishandled");
	a_dcbz_bcast: assert property (accept && op_dcbz |=>
		start_ff && aonly_ff && tt_ff == TT_KILL && nst_ff == CS_M) else $error("block zero not broadcast");
	a_abe_gate: assert property (accept && gated && !abe && !push |=> !start_ff)
		else $error("broadcast without enable");
	a_l2_forward: assert property (accept && l2_sel |=> l2_ff) else $error("block op not sent to L2");
	a_icbi_quiet: assert property (accept && req_op == OP_ICBI |=> !start_ff && nst_ff == CS_I)
		else $error("icbi caused bus activity");
	a_snoop_ignore: assert property (snp_valid && !snp_read && snp_tt != TT_KILL |=>
		!flush_ff && !kill_ff && !inh_ff) else $error("foreign broadcast acted upon");
	a_sync_hold: assert property (state_ff == ST_QWAIT && mem_queue_busy |=> !done_ff)
		else $error("sync done with busy queues");
	a_tlbsync_hold: assert property (state_ff == ST_TWAIT && tlbsync_hold |=> !done_ff)
		else $error("tlbsync done while held");
	a_touch_hit: assert property (accept && touch && req_hit |=> !start_ff && nst_ff == $past(req_state))
		else $error("touch hit caused activity");
	a_beat_wrap: assert property (beat_ff && burst_ff && $past(beat_ff) |->
		beat_addr_ff[4:3] == dw_next($past(beat_addr_ff[4:3]))) else $error("beat order wrong");

	// Handshake shape; the bench waits on these, so a stuck waitrequest or ready would only show as a timeout
	a_reg_answer: assert property (bus_req && wait_ff |=>
		!wait_ff)
		else $error("register request not answered");
	a_reg_release: assert property (!wait_ff |=>
		wait_ff)
		else $error("register answer held too long");
	a_done_pulse: assert property (done_ff |=>
		!done_ff && ready_ff)
		else $error("done not a single pulse");
	a_ready_idle: assert property (ready_ff |->
		state_ff == ST_IDLE)
		else $error("ready outside idle");
	a_state_onehot: assert property (
		$onehot(state_ff))
		else $error("state code not one-hot");
	a_start_pulse: assert property (start_ff |=>
		!start_ff)
		else $error("bus start longer than one cycle");

	// Transfer shape and encoding
	a_fill_size: assert property (start_ff && burst_ff |->
		size_ff == MAX_SINGLE)
		else $error("burst size not a full beat");
	a_beat_in_block: assert property (beat_ff && burst_ff |->
		beat_addr_ff[ADDR_W-1:5] == baddr_ff[ADDR_W-1:5])
		else $error("burst beat left its block");
	a_store_write: assert property (accept && op_st && single |=>
		tt_ff == TT_WRITE && !burst_ff)
		else $error("single store not a write");
	a_ci_read: assert property (accept && mem_op && !op_st && is_ci |=>
		tt_ff == TT_READ && !burst_ff)
		else $error("inhibited read misencoded");
	a_dcbf_push: assert property (accept && op_dcbf && st_m |=>
		start_ff && burst_ff && tt_ff == TT_WWK && nst_ff == CS_I)
		else $error("modified flush not pushed");
	a_touch_miss: assert property (accept && touch && miss |=>
		start_ff && burst_ff && tt_ff == TT_READ_INTENT_MODIFY && nst_ff == CS_E)
		else $error("touch miss not fetched exclusive");
	a_l2_only_block: assert property (accept && !l2_sel |=>
		!l2_ff)
		else $error("non-block op sent to L2");
	a_tlb_no_bus: assert property (accept && (req_op == OP_TLBSYNC || req_op == OP_TLBIE) |=>
		!start_ff)
		else $error("tlb op caused bus activity");
	a_sync_bcast: assert property (accept && op_sync && abe |=>
		start_ff && aonly_ff && tt_ff == TT_SYNC)
		else $error("enabled sync not broadcast");
	a_eieio_bcast: assert property (accept && op_eieio && abe |=>
		start_ff && aonly_ff && tt_ff == TT_EIEIO)
		else $error("enabled ordering op not broadcast");
	a_kill_pulse: assert property (snp_valid && snp_tt == TT_KILL |=>
		kill_ff && !flush_ff && !inh_ff)
		else $error("snooped kill block missed");
	a_flush_cause: assert property (flush_ff |->
		$past(snp_valid))
		else $error("flush without a snoop");

	c_burst_fill: cover property (accept && fill ##1 beat_ff [*4] ##1 done_ff);
	c_sync_wait: cover property (state_ff == ST_QWAIT && mem_queue_busy ##1 done_ff [*1]);
	c_snoop_kill: cover property (snp_valid && snp_tt == TT_KILL ##1 kill_ff);
	c_reg_read: cover property (avs_read && sel_stat ##1 !wait_ff);
	c_touch_fill: cover property (accept && touch && miss ##1 start_ff && burst_ff);
endmodule // lcbt_top
`default_nettype wire

// [hdl/lcbt_pkg.sv]
package lcbt_pkg;
	// Register map, byte offsets on the slave bus
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam int CFG_DCE_BIT = 0;
	localparam int CFG_LOCK_BIT = 1;
	localparam int CFG_ABE_BIT = 2;
	localparam int CFG_W = 3;
	localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;
	localparam int STAT_W = 6;
	// Page attribute bits, order W I M G from msb
	localparam int ATTR_W_BIT = 3;
	localparam int ATTR_I_BIT = 2;
	// Transfer type codes
	localparam logic [4:0] TT_CLEAN = 5'h00;
	localparam logic [4:0] TT_WRITE = 5'h02;
	localparam logic [4:0] TT_FLUSH = 5'h04;
	localparam logic [4:0] TT_WWK = 5'h06;
	localparam logic [4:0] TT_SYNC = 5'h08;
	localparam logic [4:0] TT_READ = 5'h0A;
	localparam logic [4:0] TT_KILL = 5'h0C;
	localparam logic [4:0] TT_READ_INTENT_MODIFY = 5'h0E;
	localparam logic [4:0] TT_EIEIO = 5'h10;
	localparam logic [1:0] BURST_LAST = 2'h3;
	localparam logic [3:0] MAX_SINGLE = 4'h8;
	typedef enum logic [1:0] {CS_I = 2'h0, CS_E = 2'h1, CS_M = 2'h2} lcbt_cst_t;
	typedef enum logic [3:0] {
		OP_LOAD = 4'h0, OP_STORE = 4'h1, OP_FETCH = 4'h2, OP_SYNC = 4'h3,
		OP_EIEIO = 4'h4, OP_TLBSYNC = 4'h5, OP_TLBIE = 4'h6, OP_ICBI = 4'h7,
		OP_DCBI = 4'h8, OP_DCBF = 4'h9, OP_DCBST = 4'hA, OP_DCBZ = 4'hB,
		OP_TOUCH = 4'hC, OP_TOUCH_ST = 4'hD
	} lcbt_op_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01, ST_XFER = 5'h02, ST_QWAIT = 5'h04,
		ST_TWAIT = 5'h08, ST_DONE = 5'h10
	} lcbt_state_t;
	function automatic logic [1:0] dw_next(input logic [1:0] dw);
		dw_next = dw + 2'h1;
	endfunction
endpackage

// [verification/lcbt_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lcbt_bus_model (
	input wire logic clk,
	output logic snp_valid,
	output logic [4:0] snp_tt,
	output logic snp_burst,
	output logic mem_queue_busy,
	output logic tlbsync_hold
);
	initial begin
		snp_valid = 0;
		snp_tt = 5'h1F;
		snp_burst = 0;
		mem_queue_busy = 0;
		tlbsync_hold = 0;
	end
	// Another master's address tenure lasts one cycle
	task snoop(input logic [4:0] tt, input logic b);
		snp_valid <= 1;
		snp_tt <= tt;
		snp_burst <= b;
		@(posedge clk);
		snp_valid <= 0;
		// Released lines flip so a stale type is never mistaken for a live one
		snp_tt <= ~tt;
		snp_burst <= ~b;
	endtask
	// The system lets the wait end only after n cycles
	task hold(input logic tlb, input int n);
		if (tlb) tlbsync_hold <= 1;
		else mem_queue_busy <= 1;
		repeat (n) @(posedge clk);
		tlbsync_hold <= 0;
		mem_queue_busy <= 0;
	endtask
endmodule // lcbt_bus_model
`default_nettype wire

// [verification/tb_l1_cache_bus_transactions.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_l1_cache_bus_transactions;
	import lcbt_pkg::*;
	logic clk = 0;
	logic resetn = 0;
	logic avs_read = 0, avs_write = 0, req_valid = 0, req_hit = 0;
	logic [3:0] avs_address = 4'h0, req_size = 4'h0, page_attribute_bits = 4'h0, bus_size, g_size;
	logic [31:0] avs_writedata = 32'h0000_0000, req_addr = 32'h0000_0000;
	logic [31:0] avs_readdata, bus_addr, beat_addr, g_addr, rd;
	logic avs_waitrequest, req_ready, req_done, bus_start, transfer_burst_flag, bus_addr_only;
	logic beat_valid, l2_forward, snp_valid, snp_burst, snp_flush, snp_inhibit, snp_kill;
	logic mem_queue_busy, tlbsync_hold, g_start, g_burst, g_ao, g_l2;
	logic [4:0] bus_tt, snp_tt, g_tt;
	lcbt_op_t req_op = OP_LOAD;
	lcbt_cst_t req_state = CS_I;
	lcbt_cst_t req_next_state;
	int err_total = 0, checks_done = 0, cyc;
	logic [31:0] beats [$];
	lcbt_op_t ops [7] = '{OP_DCBI, OP_DCBF, OP_DCBST, OP_SYNC, OP_EIEIO, OP_ICBI, OP_DCBZ};
	logic [4:0] tts [7] = '{TT_KILL, TT_FLUSH, TT_CLEAN, TT_SYNC, TT_EIEIO, TT_KILL, TT_KILL};
	always #2 clk = ~clk;
	lcbt_top dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .req_valid, .req_op, .req_addr,
		.req_size, .page_attribute_bits, .req_hit, .req_state, .req_ready, .req_done,
		.req_next_state, .mem_queue_busy, .tlbsync_hold, .bus_start, .bus_tt, .bus_addr,
		.bus_size, .transfer_burst_flag, .bus_addr_only, .beat_valid, .beat_addr, .l2_forward,
		.snp_valid, .snp_tt, .snp_burst, .snp_flush, .snp_inhibit, .snp_kill);
	lcbt_bus_model bm (.clk, .snp_valid, .snp_tt, .snp_burst, .mem_queue_busy, .tlbsync_hold);
	task end_of_test;
		$display("Checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge clk);
	endtask
	// Records what the bus side shows from accept until completion
	task issue(input lcbt_op_t op, input logic [31:0] a, input logic [3:0] sz, input logic [3:0] at,
		input logic hit, input lcbt_cst_t st);
		req_valid <= 1;
		req_op <= op;
		req_addr <= a;
		req_size <= sz;
		page_attribute_bits <= at;
		req_hit <= hit;
		req_state <= st;
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 0;
		g_start = 0;
		g_l2 = 0;
		beats = {};
		cyc = 0;
		do begin
			@(posedge clk);
			cyc++;
			if (bus_start === 1'b1) g_start = 1;
			if (bus_start === 1'b1) {g_tt, g_burst, g_ao, g_addr, g_size} = {bus_tt,
				transfer_burst_flag, bus_addr_only, bus_addr, bus_size};
			if (beat_valid === 1'b1) beats.push_back(beat_addr);
			if (l2_forward === 1'b1) g_l2 = 1;
		end while (req_done !== 1'b1 && cyc < 60);
	endtask
	task chk_beats(input logic [31:0] b0);
		logic [1:0] dw;
		chk(beats.size(), 4);
		for (int i = 0; i < 4 && i < beats.size(); i++) begin
			dw = b0[4:3] + i[1:0];
			chk(beats[i], {b0[31:5], dw, 3'h0});
		end
	endtask
	task t_regs;
		av(0, REG_CFG, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		av(1, REG_CFG, 32'hFFFF_FFFF);
		av(0, REG_CFG, 32'h0000_0000);
		chk(rd, 32'h0000_0007);
		av(0, 4'hC, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		av(0, REG_STAT, 32'h0000_0000);
		chk(rd, 32'h0000_0021);
		av(1, REG_CFG, 32'h0000_0001);
	endtask
	task t_fill;
		issue(OP_LOAD, 32'h0000_101C, 4'h8, 4'h2, 0, CS_I);
		chk({g_tt, g_burst}, {TT_READ_INTENT_MODIFY, 1'b1});
		chk(g_addr, 32'h0000_1018);
		chk_beats(32'h0000_1018);
		issue(OP_FETCH, 32'h0000_2014, 4'h8, 4'h2, 0, CS_I);
		chk(g_burst, 1);
		chk_beats(32'h0000_2010);
	endtask
	task t_single;
		for (int i = 0; i < 4; i++) begin
			av(1, REG_CFG, i == 2 ? 32'h0000_0000 : i == 3 ? 32'h0000_0003 : 32'h0000_0001);
			issue(i == 0 ? OP_STORE : OP_LOAD, 32'h0000_3005, 4'h3, i == 0 ? 4'h8 : i == 1 ? 4'h4 : 4'h0, 0, CS_I);
			chk(g_burst, 0);
			chk({g_addr, g_size}, {32'h0000_3005, 4'h3});
			chk(beats.size(), 1);
			if (i == 1) chk(g_tt, TT_READ);
		end
	endtask
	task t_bcast;
		for (int e = 0; e < 2; e++) begin
			av(1, REG_CFG, e ? 32'h0000_0005 : 32'h0000_0001);
			for (int k = 0; k < 7; k++) begin
				issue(ops[k], 32'h0000_4010, 4'h0, 4'h2, 1, CS_E);
				chk(g_start, k == 6 || (k < 5 && e == 1));
				if (g_start === 1'b1) chk({g_tt, g_ao}, {tts[k], 1'b1});
				chk(g_l2, k < 3 || k == 6);
			end
			chk(req_next_state, CS_M);
		end
	endtask
	task t_push;
		issue(OP_DCBST, 32'h0000_501C, 4'h0, 4'h2, 1, CS_M);
		chk({g_tt, req_next_state}, {TT_WWK, CS_E});
		chk_beats(32'h0000_5000);
		issue(OP_DCBF, 32'h0000_7014, 4'h0, 4'h2, 1, CS_M);
		chk({g_tt, req_next_state}, {TT_WWK, CS_I});
		chk_beats(32'h0000_7000);
		issue(OP_TOUCH, 32'h0000_6008, 4'h0, 4'h2, 0, CS_I);
		chk({g_tt, req_next_state}, {TT_READ_INTENT_MODIFY, CS_E});
		issue(OP_TOUCH_ST, 32'h0000_6008, 4'h0, 4'h2, 1, CS_E);
		chk({g_start, req_next_state}, {1'b0, CS_E});
	endtask
	task snp(input logic [4:0] tt, input logic b, input logic [2:0] exp);
		bm.snoop(tt, b);
		@(posedge clk);
		chk({snp_flush, snp_inhibit, snp_kill}, exp);
	endtask
	task t_snoop;
		snp(TT_READ_INTENT_MODIFY, 1, 3'h4);
		snp(TT_READ, 1, 3'h4);
		snp(TT_READ, 0, 3'h2);
		snp(TT_KILL, 0, 3'h1);
		snp(TT_CLEAN, 0, 3'h0);
		snp(TT_FLUSH, 0, 3'h0);
		snp(TT_SYNC, 0, 3'h0);
	endtask
	task t_wait;
		fork
			bm.hold(0, 6);
			issue(OP_SYNC, 32'h0000_0000, 4'h0, 4'h2, 0, CS_E);
		join
		chk(cyc > 6 && cyc < 60, 1);
		fork
			bm.hold(1, 9);
			issue(OP_TLBSYNC, 32'h0000_0000, 4'h0, 4'h2, 0, CS_E);
		join
		chk(cyc > 9 && cyc < 60, 1);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		t_regs;
		t_fill;
		t_single;
		t_bcast;
		t_push;
		t_snoop;
		t_wait;
		end_of_test;
	end
	// Whole run needs about 150 cycles; this leaves wide margin
	initial begin
		#40000;
		err_total++;
		end_of_test;
	end
endmodule // tb_l1_cache_bus_transactions
`default_nettype wire
